// file: lscr_pkg.sv
package lscr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CFG1 = 6'h14;
  localparam logic [5:0] IDX_CFG2 = 6'h15;
  localparam logic [5:0] IDX_UNLOCK = 6'h0b;

  // field positions inside each configuration byte
  localparam int unsigned MODE_BIT = 5;
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned CODE_W = 5;

  // reset values, one variant chosen per instance
  localparam logic [7:0] CFG1_RST_DEFAULT = 8'h06;
  localparam logic [7:0] CFG2_RST_DEFAULT = 8'h15;

  // unlock key; the value is arbitrary
  localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5a;

  // voltage table corners in millivolts
  localparam int unsigned MV_W = 12;
  localparam logic [MV_W-1:0] MV_BASE_LOW = 12'd1500;
  localparam logic [MV_W-1:0] MV_KNEE = 12'd1900;
  localparam logic [MV_W-1:0] MV_CODE14 = 12'd2450;
  localparam logic [MV_W-1:0] MV_CODE15 = 12'd2500;
  localparam logic [MV_W-1:0] MV_BASE_HIGH = 12'd2550;
  localparam logic [MV_W-1:0] MV_STEP_FINE = 12'd50;
  localparam logic [MV_W-1:0] MV_STEP_COARSE = 12'd100;
  localparam logic [CODE_W-1:0] CODE_KNEE = 5'h08;
  localparam logic [CODE_W-1:0] CODE_COARSE_END = 5'h0d;
  localparam logic [CODE_W-1:0] CODE_14 = 5'h0e;
  localparam logic [CODE_W-1:0] CODE_HIGH = 5'h10;

  typedef struct packed {
    logic mode;
    logic [CODE_W-1:0] code;
  } lscr_cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } lscr_apb_req_t;

endpackage

// file: lscr_regs.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - first register bits 7 and 6 are read-only and read zero
// RQ2 - first register bit 5 picks load switch (0) or linear regulator (1)
// RQ3 - first register bits 4..0 hold voltage code, used only in regulator mode
// RQ4 - codes 0..15 give 1.5-1.9 V by 50 mV, 100 mV to 2.4, then 2.45, 2.5
// RQ5 - codes 16..31 give 2.55 V to 3.3 V in 50 mV steps
// RQ6 - second register sits at index 0x15, reset value set per variant
// RQ7 - second register accepts writes only after the unlock step
// RQ8 - second register has the same layout as the first
// RQ9 - first register sits at index 0x14, variant reset, unlock protected
// RQ10 - writes to reserved bits are dropped, they keep reading zero
module lscr_regs #(
  parameter logic [7:0] CFG1_RST = lscr_pkg::CFG1_RST_DEFAULT,
  parameter logic [7:0] CFG2_RST = lscr_pkg::CFG2_RST_DEFAULT,
  parameter logic [7:0] UNLOCK_KEY = lscr_pkg::UNLOCK_KEY_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire lscr_pkg::lscr_apb_req_t apb_req,
  output logic pready,
  output logic pslverr,
  output logic [lscr_pkg::DATA_W-1:0] prdata,
  output lscr_pkg::lscr_cfg_t switch1_cfg,
  output lscr_pkg::lscr_cfg_t switch2_cfg,
  output logic [lscr_pkg::MV_W-1:0] regulator3_mv,
  output logic [lscr_pkg::MV_W-1:0] regulator4_mv
);
  import lscr_pkg::*;

  // maps a voltage code to millivolts
  function automatic logic [MV_W-1:0] code_to_mv(input logic [CODE_W-1:0] c);
    logic [MV_W-1:0] cw;
    cw = {{(MV_W-CODE_W){1'b0}}, c};
    if (c <= CODE_KNEE)
      code_to_mv = MV_BASE_LOW + MV_STEP_FINE * cw; // [RQ4]
    else if (c <= CODE_COARSE_END)
      code_to_mv = MV_KNEE + MV_STEP_COARSE * (cw - {{(MV_W-CODE_W){1'b0}}, CODE_KNEE}); // [RQ4]
    else if (c == CODE_14)
      code_to_mv = MV_CODE14; // [RQ4]
    else if (c < CODE_HIGH)
      code_to_mv = MV_CODE15; // [RQ4]
    else
      code_to_mv = MV_BASE_HIGH + MV_STEP_FINE * (cw - {{(MV_W-CODE_W){1'b0}}, CODE_HIGH}); // [RQ5]
  endfunction

  function automatic lscr_cfg_t byte_to_cfg(input logic [7:0] b);
    byte_to_cfg.mode = b[MODE_BIT];
    byte_to_cfg.code = b[CODE_LSB +: CODE_W];
  endfunction

  function automatic logic [DATA_W-1:0] cfg_to_word(input lscr_cfg_t c);
    cfg_to_word = {{(DATA_W-6){1'b0}}, c.mode, c.code}; // [RQ1] [RQ8]
  endfunction

  lscr_cfg_t cfg1_q;
  lscr_cfg_t cfg1_d;
  lscr_cfg_t cfg2_q;
  lscr_cfg_t cfg2_d;
  logic armed_q;
  logic armed_d;
  logic [5:0] arm_idx_q;
  logic [5:0] arm_idx_d;
  logic [MV_W-1:0] mv3_q;
  logic [MV_W-1:0] mv4_q;

  wire [5:0] idx = apb_req.paddr[ADDR_W-1:2];
  wire aligned = (apb_req.paddr[1:0] == 2'b00);
  wire access = apb_req.psel & apb_req.penable;
  wire wr = access & apb_req.pwrite;
  wire hit_cfg1 = aligned & (idx == IDX_CFG1); // [RQ9]
  wire hit_cfg2 = aligned & (idx == IDX_CFG2); // [RQ6]
  wire hit_unlock = aligned & (idx == IDX_UNLOCK);
  wire mapped = hit_cfg1 | hit_cfg2 | hit_unlock;
  wire hit_prot = hit_cfg1 | hit_cfg2;
  wire unlocked = armed_q & (arm_idx_q == idx);
  wire key_ok = (apb_req.pwdata[7:0] == (UNLOCK_KEY ^ {2'b00, apb_req.pwdata[13:8]}));
  wire prot_ok = wr & hit_prot & unlocked & apb_req.pstrb[0]; // [RQ7] [RQ9]
  wire refuse = access & (~mapped | (apb_req.pwrite & hit_prot & ~unlocked));
  wire [7:0] wbyte = apb_req.pwdata[7:0];

  // reserved bits 7..6 are simply not stored
  assign cfg1_d = (prot_ok & hit_cfg1) ? byte_to_cfg(wbyte) : cfg1_q; // [RQ2] [RQ3] [RQ10]
  assign cfg2_d = (prot_ok & hit_cfg2) ? byte_to_cfg(wbyte) : cfg2_q; // [RQ8] [RQ10]

  // unlock word: bits 13..8 name the target index, bits 7..0 its key
  // any other completed write drops the unlock
  assign armed_d = wr ? (hit_unlock & key_ok & apb_req.pstrb[0]) : armed_q; // [RQ7]
  assign arm_idx_d = (wr & hit_unlock) ? apb_req.pwdata[13:8] : arm_idx_q;

  assign pready = 1'b1;
  assign pslverr = refuse;
  assign prdata = ~(access & ~apb_req.pwrite) ? '0 :
                  hit_cfg1 ? cfg_to_word(cfg1_q) :
                  hit_cfg2 ? cfg_to_word(cfg2_q) :
                  hit_unlock ? {{(DATA_W-7){1'b0}}, arm_idx_q, armed_q} : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg1_q <= byte_to_cfg(CFG1_RST); // [RQ9]
      cfg2_q <= byte_to_cfg(CFG2_RST); // [RQ6]
      armed_q <= 1'b0;
      arm_idx_q <= 6'h00;
    end
    else
    begin
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      armed_q <= armed_d;
      arm_idx_q <= arm_idx_d;
    end
  end

  // the code drives the regulator only in regulator mode, else output is 0 mV
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mv3_q <= '0;
      mv4_q <= '0;
    end
    else
    begin
      mv3_q <= cfg1_q.mode ? code_to_mv(cfg1_q.code) : '0; // [RQ3]
      mv4_q <= cfg2_q.mode ? code_to_mv(cfg2_q.code) : '0; // [RQ3] [RQ8]
    end
  end

  assign switch1_cfg = cfg1_q;
  assign switch2_cfg = cfg2_q;
  assign regulator3_mv = mv3_q;
  assign regulator4_mv = mv4_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence unlock_s(logic [5:0] t);
    wr && hit_unlock && key_ok && apb_req.pstrb[0] && apb_req.pwdata[13:8] == t;
  endsequence

  // unlock stays armed across the setup cycle of the next transfer
  sequence armed_s(logic [5:0] t);
    armed_q && arm_idx_q == t;
  endsequence

  rsvd_zero_a: assert property (access && !apb_req.pwrite && hit_prot |-> prdata[7:6] == 2'b00) // [RQ1]
    else $error("reserved bits read nonzero");
  reserved_write_a: assert property (prot_ok && hit_cfg1 |=> prdata[31:6] == '0 || !hit_cfg1) // [RQ10]
    else $error("reserved bits took a write");
  mode_store_a: assert property (prot_ok && hit_cfg1 |=> switch1_cfg.mode == $past(wbyte[MODE_BIT])) // [RQ2]
    else $error("mode bit not stored");
  code_gate_a: assert property (!switch1_cfg.mode |=> regulator3_mv == '0) // [RQ3]
    else $error("code active in switch mode");
  low_table_a: assert property (switch2_cfg.mode && switch2_cfg.code == 5'h0d |=> regulator4_mv == 12'd2400) // [RQ4]
    else $error("low table value wrong");
  high_table_a: assert property (switch1_cfg.mode && switch1_cfg.code == 5'h1f |=> regulator3_mv == 12'd3300) // [RQ5]
    else $error("high table value wrong");
  locked_write_a: assert property (wr && hit_cfg2 && !unlocked |=> $stable(switch2_cfg)) // [RQ6] [RQ7]
    else $error("locked write changed register");
  unlock_path_a: assert property (armed_s(IDX_CFG2) ##0 (wr && hit_cfg2 && apb_req.pstrb[0]) // [RQ7] [RQ8]
    |=> switch2_cfg == byte_to_cfg($past(wbyte)))
    else $error("unlocked write lost");
  first_addr_a: assert property (armed_s(IDX_CFG1) ##0 (wr && hit_cfg1) |-> !pslverr) // [RQ9]
    else $error("unlocked first register refused");

  // unlock bookkeeping, refusals and idle read data
  arm_first_a: assert property (unlock_s(IDX_CFG1) // [RQ9]
    |=> armed_s(IDX_CFG1))
    else $error("unlock of first register not armed");
  arm_second_a: assert property (unlock_s(IDX_CFG2) // [RQ7]
    |=> armed_s(IDX_CFG2))
    else $error("unlock of second register not armed");
  arm_drop_a: assert property (wr && !hit_unlock // [RQ7]
    |=> !armed_q)
    else $error("unlock survived a write");
  locked_err_a: assert property (wr && hit_prot && !unlocked // [RQ7]
    |-> pslverr)
    else $error("locked write not refused");
  locked_first_a: assert property (wr && hit_cfg1 && !unlocked // [RQ9]
    |=> $stable(switch1_cfg))
    else $error("locked write changed first register");
  unmapped_err_a: assert property (access && !mapped
    |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  read_idle_a: assert property (!(access && !apb_req.pwrite)
    |-> prdata == '0)
    else $error("read data outside read access");

  // stored fields and second regulator gate
  code_store_a: assert property (prot_ok && hit_cfg1 // [RQ3]
    |=> switch1_cfg.code == $past(wbyte[4:0]))
    else $error("code field not stored");
  mode2_gate_a: assert property (!switch2_cfg.mode // [RQ3] [RQ8]
    |=> regulator4_mv == '0)
    else $error("second code active in switch mode");

  // voltage table corners
  zero_code_a: assert property (switch1_cfg.mode && switch1_cfg.code == 5'h00 // [RQ4]
    |=> regulator3_mv == 12'd1500)
    else $error("lowest code value wrong");
  knee_code_a: assert property (switch1_cfg.mode && switch1_cfg.code == 5'h08 // [RQ4]
    |=> regulator3_mv == 12'd1900)
    else $error("knee code value wrong");
  code14_a: assert property (switch1_cfg.mode && switch1_cfg.code == 5'h0e // [RQ4]
    |=> regulator3_mv == 12'd2450)
    else $error("code 14 value wrong");
  code15_a: assert property (switch1_cfg.mode && switch1_cfg.code == 5'h0f // [RQ4]
    |=> regulator3_mv == 12'd2500)
    else $error("code 15 value wrong");
  high_base_a: assert property (switch1_cfg.mode && switch1_cfg.code == 5'h10 // [RQ5]
    |=> regulator3_mv == 12'd2550)
    else $error("upper table base wrong");
endmodule

// file: tb_lscr_regs.sv
`timescale 1ns/1ps
module tb_lscr_regs;
  import lscr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  lscr_apb_req_t req = '0;
  logic pready;
  logic pslverr;
  logic [DATA_W-1:0] prdata;
  lscr_cfg_t cfg1;
  lscr_cfg_t cfg2;
  logic [MV_W-1:0] mv3;
  logic [MV_W-1:0] mv4;
  logic [DATA_W-1:0] cap_rd = '0;
  logic cap_err = 1'b0;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  lscr_regs dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .switch1_cfg(cfg1), .switch2_cfg(cfg2), .regulator3_mv(mv3), .regulator4_mv(mv4));
  always #2.5 pclk = ~pclk;
  // answer captured at the completing edge, before that edge's updates land
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      wrap_up();
    end
    if (req.psel && req.penable && pready)
    begin
      cap_rd <= prdata;
      cap_err <= pslverr;
    end
  end
  task automatic wrap_up();
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'h1};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    req <= '0;
    @(negedge pclk);
  endtask
  task automatic unlock(input logic [5:0] idx);
    apb(1'b1, {IDX_UNLOCK, 2'b00}, {18'h0, idx, UNLOCK_KEY_DEFAULT ^ {2'b00, idx}});
  endtask
  task automatic wcfg(input logic [5:0] idx, input logic [31:0] d);
    unlock(idx);
    apb(1'b1, {idx, 2'b00}, d);
  endtask
  function automatic int exp_mv(input int c);
    if (c <= 8) return 1500 + 50 * c;
    if (c <= 13) return 1900 + 100 * (c - 8);
    if (c == 14) return 2450;
    if (c == 15) return 2500;
    return 2550 + 50 * (c - 16);
  endfunction
  task automatic t_reset_and_lock();
    apb(1'b0, 8'h50, 32'h0);
    chk(cap_rd, 32'h06);
    apb(1'b0, 8'h54, 32'h0);
    chk(cap_rd, 32'h15);
    chk({20'h0, mv3}, 32'h0);
    apb(1'b1, 8'h50, 32'h3f);
    chk({31'h0, cap_err}, 32'h1);
    apb(1'b0, 8'h50, 32'h0);
    chk(cap_rd, 32'h06);
  endtask
  task automatic t_reserved();
    wcfg(IDX_CFG1, 32'hff);
    chk({31'h0, cap_err}, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk(cap_rd, 32'h3f);
    chk({26'h0, cfg1}, 32'h3f);
  endtask
  task automatic t_table();
    for (int c = 0; c < 32; c++)
    begin
      wcfg(IDX_CFG1, 32'h20 | c);
      @(posedge pclk);
      @(negedge pclk);
      chk({20'h0, mv3}, exp_mv(c));
    end
    wcfg(IDX_CFG1, 32'h1f);
    @(posedge pclk);
    @(negedge pclk);
    chk({20'h0, mv3}, 32'h0);
  endtask
  task automatic t_second();
    wcfg(IDX_CFG2, 32'hed);
    apb(1'b0, 8'h54, 32'h0);
    chk(cap_rd, 32'h2d);
    chk({20'h0, mv4}, exp_mv(13));
    apb(1'b1, 8'h54, 32'h11);
    chk({31'h0, cap_err}, 32'h1);
    chk({26'h0, cfg2}, 32'h2d);
  endtask
  task automatic t_order();
    unlock(IDX_CFG1);
    apb(1'b0, 8'h50, 32'h0);
    apb(1'b1, 8'h50, 32'h21);
    chk({26'h0, cfg1}, 32'h21);
    unlock(IDX_CFG1);
    apb(1'b1, 8'h40, 32'h0);
    chk({31'h0, cap_err}, 32'h1);
    apb(1'b1, 8'h50, 32'h05);
    chk({31'h0, cap_err}, 32'h1);
    chk({26'h0, cfg1}, 32'h21);
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_lock();
    t_reserved();
    t_table();
    t_second();
    t_order();
    wrap_up();
  end
endmodule
